// ==== include/stb_pkg.sv ====
// Package for the tag bus controller: bus widths, tag codes, control word bits,
// status bits and timing counts.
// Assumes a 25 MHz system clock.
package stb_pkg;
  localparam int BUS_OUT_W      = 10;
  localparam int BUS_IN_W       = 8;
  localparam int UNIT_W         = 4;
  localparam int NUM_TAGS       = 6;

  // Control word bit positions under the control tag
  localparam int CTL_WRITE_WIN  = 0;
  localparam int CTL_READ_WIN   = 1;
  localparam int CTL_OFS_PLUS   = 2;
  localparam int CTL_OFS_MINUS  = 3;
  localparam int CTL_FAULT_CLR  = 4;
  localparam int CTL_AM_ENABLE  = 5;
  localparam int CTL_RTZ        = 6;
  localparam int CTL_STB_EARLY  = 7;
  localparam int CTL_STB_LATE   = 8;
  localparam int CTL_RELEASE    = 9;

  // Basic status bit positions
  localparam int ST_READY       = 0;
  localparam int ST_ON_CYL      = 1;
  localparam int ST_SEEK_ERR    = 2;
  localparam int ST_FAULT       = 3;
  localparam int ST_WR_PROT     = 4;
  localparam int ST_ADDRESS_MARK_FOUND = 5;
  localparam int ST_INDEX       = 6;
  localparam int ST_SECTOR      = 7;

  // Setup/hold and strobe width in cycles
  localparam int SETUP_CYC      = 1;
  localparam int STROBE_CYC     = 1;
  localparam int HOLD_CYC       = 1;
  localparam int CNT_W          = 4;
  localparam logic [CNT_W-1:0] SETUP_CNT  = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] HOLD_CNT   = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;

  // Function tags (bus out meaning selector)
  typedef enum logic [2:0] {
    TAG_CYL    = 3'h0,
    TAG_HEAD   = 3'h1,
    TAG_CTRL   = 3'h2,
    TAG_SECTOR = 3'h3,
    TAG_EXT    = 3'h4,
    TAG_DEVTYP = 3'h5
  } stb_tag_e;

  typedef struct packed {
    stb_tag_e               tag;
    logic [BUS_OUT_W-1:0]   word;
  } stb_cmd_s;

  typedef struct packed {
    logic [BUS_OUT_W-1:0]   bus_out;
    logic [NUM_TAGS-1:0]    tag_strobe;
    logic [UNIT_W-1:0]      unit_num;
    logic                   unit_strobe;
  } stb_link_s;
endpackage

// ==== design/stb_tag_bus_ctrl.sv ====
// Tag bus controller: selects a drive over unit lines and its own strobe,
// then issues function words on the command bus under one of six tag strobes.
// Assumes the drive's lines are synchronous to i_sys_clk; cable drivers are outside.
// Functional notes
// - Every address and control word goes out on a ten-line command bus.
// - Which of six tag strobes is pulsed sets what the command word means.
// - A drive is selected by unit number lines latched with their own unit strobe.
// - Tag strobes other than the unit strobe are sent only while the drive acknowledges selection.
// - The unit number field addresses up to sixteen drives.
// - Commands and status use only the control cable; serial data uses the data cable.
// - Dual-port drives arbitrate with priority claim, busy and release lines; here claim and busy are only registered out, and there is no release line.
// - Under the control tag bits 0 to 9 are write, read, offset plus/minus, fault clear, AM enable, RTZ, early, late, release.
`timescale 1ns/1ps
module stb_tag_bus_ctrl (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_sys_rst,
  input  wire logic                       i_sel_valid,
  output logic                            o_sel_ready,
  input  wire logic [stb_pkg::UNIT_W-1:0] i_sel_unit,
  input  wire logic                       i_cmd_valid,
  output logic                            o_cmd_ready,
  input  wire stb_pkg::stb_cmd_s          i_cmd,
  input  wire logic                       i_priority_claim,
  input  wire logic                       i_unit_selected,
  input  wire logic [stb_pkg::BUS_IN_W-1:0] i_bus_in,
  input  wire logic                       i_busy,
  output stb_pkg::stb_link_s              o_link,
  output logic                            o_priority_select,
  output logic                            o_selected,
  output logic                            o_busy_seen,
  output logic [stb_pkg::BUS_IN_W-1:0]    o_status,
  output logic                            o_write_refused
);

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} stb_state_e;

  stb_state_e                         state_reg;
  logic [stb_pkg::CNT_W-1:0]          cnt_reg;
  logic                               is_unit_reg;
  logic [stb_pkg::BUS_OUT_W-1:0]      bus_out_reg;
  stb_pkg::stb_tag_e                  tag_reg;
  logic [stb_pkg::UNIT_W-1:0]         unit_reg;
  logic [stb_pkg::NUM_TAGS-1:0]       tag_stb_reg;
  logic                               unit_stb_reg;
  logic [stb_pkg::BUS_IN_W-1:0]       status_reg;
  logic                               refused_reg;
  logic                               selected_reg;
  logic                               busy_reg;
  logic                               prio_reg;

  function automatic logic [stb_pkg::NUM_TAGS-1:0] tag_onehot(input stb_pkg::stb_tag_e t);
    logic [stb_pkg::NUM_TAGS-1:0] v;
    v = '0;
    v[t] = 1'b1;
    return v;
  endfunction

  // Write window is legal only with the drive ready, on cylinder and without seek error, write protect or fault
  function automatic logic write_legal(input logic [stb_pkg::BUS_IN_W-1:0] st);
    return st[stb_pkg::ST_READY] && st[stb_pkg::ST_ON_CYL] && !st[stb_pkg::ST_SEEK_ERR]
           && !st[stb_pkg::ST_WR_PROT] && !st[stb_pkg::ST_FAULT];
  endfunction

  logic idle;
  logic wr_req;
  assign idle        = (state_reg == S_IDLE);
  assign o_sel_ready = idle;
  assign wr_req      = (i_cmd.tag == stb_pkg::TAG_CTRL) && i_cmd.word[stb_pkg::CTL_WRITE_WIN];
  // Function strobes only while the drive acknowledges selection
  assign o_cmd_ready = idle && !i_sel_valid && i_unit_selected;

  logic take_sel;
  logic take_cmd;
  logic take_refuse;
  assign take_sel    = idle && i_sel_valid;
  assign take_cmd    = o_cmd_ready && i_cmd_valid && !(wr_req && !write_legal(status_reg));
  assign take_refuse = o_cmd_ready && i_cmd_valid && wr_req && !write_legal(status_reg);

  // Sequencer: setup, strobe, hold
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_reg <= S_IDLE;
      cnt_reg   <= stb_pkg::CNT_ZERO;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (take_sel || take_cmd) begin
            state_reg <= S_SETUP;
            cnt_reg   <= stb_pkg::SETUP_CNT;
          end
        end
        S_SETUP: begin
          if (cnt_reg == stb_pkg::CNT_ONE) begin
            state_reg <= S_STROBE;
            cnt_reg   <= stb_pkg::STROBE_CNT;
          end else begin
            cnt_reg <= cnt_reg - stb_pkg::CNT_ONE;
          end
        end
        S_STROBE: begin
          if (cnt_reg == stb_pkg::CNT_ONE) begin
            state_reg <= S_HOLD;
            cnt_reg   <= stb_pkg::HOLD_CNT;
          end else begin
            cnt_reg <= cnt_reg - stb_pkg::CNT_ONE;
          end
        end
        S_HOLD: begin
          if (cnt_reg == stb_pkg::CNT_ONE) begin
            state_reg <= S_IDLE;
            cnt_reg   <= stb_pkg::CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg - stb_pkg::CNT_ONE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          cnt_reg   <= stb_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // Unit number is latched on a selection and held until the next one
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      unit_reg <= '0;
    end else if (take_sel) begin
      unit_reg <= i_sel_unit;
    end
  end

  // Command word is latched once and held through setup, strobe and hold
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      bus_out_reg <= '0;
      tag_reg     <= stb_pkg::TAG_CYL;
    end else if (take_cmd) begin
      bus_out_reg <= i_cmd.word;
      tag_reg     <= i_cmd.tag;
    end
  end

  // Whether the running sequence ends in the unit strobe or a tag strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      is_unit_reg <= 1'b0;
    end else if (take_sel) begin
      is_unit_reg <= 1'b1;
    end else if (take_cmd) begin
      is_unit_reg <= 1'b0;
    end
  end

  // Strobes are registered and rise only in the strobe phase
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tag_stb_reg  <= '0;
      unit_stb_reg <= 1'b0;
    end else if (state_reg == S_SETUP && cnt_reg == stb_pkg::CNT_ONE) begin
      tag_stb_reg  <= is_unit_reg ? '0 : tag_onehot(tag_reg);
      unit_stb_reg <= is_unit_reg;
    end else if (state_reg == S_STROBE && cnt_reg == stb_pkg::CNT_ONE) begin
      tag_stb_reg  <= '0;
      unit_stb_reg <= 1'b0;
    end
  end

  // Status bus capture
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      status_reg <= '0;
    end else begin
      status_reg <= i_bus_in;
    end
  end

  // Selection acknowledge from the drive
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      selected_reg <= 1'b0;
    end else begin
      selected_reg <= i_unit_selected;
    end
  end

  // Dual-port arbitration lines
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      busy_reg <= 1'b0;
      prio_reg <= 1'b0;
    end else begin
      busy_reg <= i_busy;
      prio_reg <= i_priority_claim;
    end
  end

  // One-cycle pulse for each refused write command
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= take_refuse;
    end
  end

  // Only control cable lines leave this block; no serial data path here
  always_comb begin
    o_link.bus_out     = bus_out_reg;
    o_link.tag_strobe  = tag_stb_reg;
    o_link.unit_num    = unit_reg;
    o_link.unit_strobe = unit_stb_reg;
  end

  assign o_priority_select = prio_reg;
  assign o_selected        = selected_reg;
  assign o_busy_seen       = busy_reg;
  assign o_status          = status_reg;
  assign o_write_refused   = refused_reg;

endmodule

// ==== dv/stb_ctrl_asserts.sv ====
// Checker for the tag bus controller ports.
// Assumes one clock with synchronous active-high reset.
`timescale 1ns/1ps
module stb_ctrl_asserts (
  input wire logic               i_sys_clk,
  input wire logic               i_sys_rst,
  input wire logic               i_sel_valid,
  input wire logic               o_sel_ready,
  input wire logic [3:0]         i_sel_unit,
  input wire logic               i_cmd_valid,
  input wire logic               o_cmd_ready,
  input wire stb_pkg::stb_cmd_s  i_cmd,
  input wire logic               i_unit_selected,
  input wire stb_pkg::stb_link_s o_link,
  input wire logic [7:0]         o_status,
  input wire logic               o_write_refused
);
  logic       take;
  logic       sel_take;
  logic       stb;
  logic [5:0] tg;
  assign take = i_cmd_valid && o_cmd_ready;
  assign sel_take = i_sel_valid && o_sel_ready;
  assign tg = o_link.tag_strobe;
  assign stb = |tg;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  AST_ONE_HOT: assert property ($onehot0(tg))
    else $error("tag strobes overlap");
  AST_TAG_MAP: assert property (stb |-> tg == 6'h01 << $past(i_cmd.tag, 2))
    else $error("wrong tag strobe");
  AST_ACK_GATE: assert property (stb |-> $past(take, 2) && $past(i_unit_selected, 2))
    else $error("strobe without acknowledge");
  AST_WORD: assert property (stb |-> $stable(o_link.bus_out) && o_link.bus_out == $past(i_cmd.word, 2))
    else $error("command word wrong at strobe");
  AST_HOLD: assert property ($fell(stb) |-> $stable(o_link.bus_out))
    else $error("command word moved at strobe end");
  AST_UNIT: assert property (sel_take |-> ##2 o_link.unit_strobe
    && o_link.unit_num == $past(i_sel_unit, 2) ##1 !o_link.unit_strobe) else $error("unit strobe wrong");
  AST_READY_GATE: assert property (o_cmd_ready |-> i_unit_selected && !i_sel_valid)
    else $error("command ready while unselected");
  AST_WR_REFUSE: assert property (take && i_cmd.tag == stb_pkg::TAG_CTRL && i_cmd.word[0]
    && o_status[4:0] != 5'h03 |=> o_write_refused ##1 !stb) else $error("bad write not refused");
endmodule
bind stb_tag_bus_ctrl stb_ctrl_asserts u_chk (.*);

// ==== dv/stb_drive_model.sv ====
// Drive model on the control cable: acknowledges selection, returns status.
// Assumes the controller clock; basic status is set by the bench.
`timescale 1ns/1ps
module stb_drive_model #(
  parameter logic [3:0] MY_UNIT = 4'h5
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_sys_rst,
  input  wire stb_pkg::stb_link_s i_link,
  input  wire logic [7:0]         i_basic,
  output logic                    o_unit_selected,
  output logic [7:0]              o_bus_in
);
  logic fault_reg;
  logic ctl;
  assign ctl = o_unit_selected && i_link.tag_strobe[2];
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) o_unit_selected <= 1'b0;
    else if (i_link.unit_strobe) o_unit_selected <= i_link.unit_num == MY_UNIT;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) fault_reg <= 1'b0;
    else if (ctl && i_link.bus_out[0] && i_basic[4:0] != 5'h03) fault_reg <= 1'b1;
    else if (ctl && i_link.bus_out[4]) fault_reg <= 1'b0;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) o_bus_in <= 8'h5a;
    else if (!o_unit_selected) o_bus_in <= ~o_bus_in; // Unselected bus keeps no value
    else o_bus_in <= i_basic | {4'h0, fault_reg, 3'h0};
  end
endmodule

// ==== dv/tb_smd_tag_bus_controller.sv ====
// Self-checking bench: controller against one drive model.
// Assumes package, design, checker and model compiled first.
`timescale 1ns/1ps
module tb_smd_tag_bus_controller;
  logic               clk = 1'b0, rst = 1'b1, sel_v = 1'b0, cmd_v = 1'b0, claim = 1'b0, busy = 1'b0;
  logic [3:0]         sel_u = 4'h0;
  logic [7:0]         basic = 8'h03;
  stb_pkg::stb_cmd_s  cmd = '0;
  logic               usel, sel_rdy, cmd_rdy, psel, selected, wref, busy_seen;
  logic [7:0]         bus_in, status;
  stb_pkg::stb_link_s link;
  int                 fail_count = 0, compares = 0;
  stb_tag_bus_ctrl dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_sel_valid(sel_v), .o_sel_ready(sel_rdy),
    .i_sel_unit(sel_u), .i_cmd_valid(cmd_v), .o_cmd_ready(cmd_rdy), .i_cmd(cmd), .i_priority_claim(claim),
    .i_unit_selected(usel), .i_bus_in(bus_in), .i_busy(busy), .o_link(link), .o_priority_select(psel),
    .o_selected(selected), .o_busy_seen(busy_seen), .o_status(status), .o_write_refused(wref));
  stb_drive_model u_drv (.i_sys_clk(clk), .i_sys_rst(rst), .i_link(link), .i_basic(basic),
    .o_unit_selected(usel), .o_bus_in(bus_in));
  initial forever #20 clk = ~clk;
  task automatic end_sim;
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic t_sel(input logic [3:0] u, input logic e);
    for (int n = 0; n < 9 && sel_rdy !== 1'b1; n++) cyc(1);
    sel_v = 1'b1;
    sel_u = u;
    cyc(1);
    sel_v = 1'b0;
    cyc(1);
    chk("unit_num", 16'(u), 16'(link.unit_num));
    chk("unit_strobe", 16'h1, 16'(link.unit_strobe));
    chk("sel_ready", 16'h0, 16'(sel_rdy));
    cyc(2);
    chk("selected", 16'(e), 16'(selected));
    chk("cmd_ready", 16'(e), 16'(cmd_rdy));
  endtask
  task automatic t_cmd(input stb_pkg::stb_tag_e tg, input logic [9:0] w, input logic [5:0] es);
    for (int n = 0; n < 9 && cmd_rdy !== 1'b1; n++) cyc(1);
    cmd_v = 1'b1;
    cmd.tag = tg;
    cmd.word = w;
    cyc(1);
    cmd_v = 1'b0;
    chk("write_refused", 16'(es == 6'h00), 16'(wref));
    cyc(1);
    chk("tag_strobe", 16'(es), 16'(link.tag_strobe));
    if (es != 6'h00) chk("bus_out", 16'(w), 16'(link.bus_out));
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_sel(4'hf, 1'b0);
    t_sel(4'h5, 1'b1);
    for (int t = 0; t < 6; t++) t_cmd(stb_pkg::stb_tag_e'(t), 10'h2a5 ^ 10'(t), 6'h01 << t);
    for (int b = 0; b < 10; b++) t_cmd(stb_pkg::TAG_CTRL, 10'h001 << b, 6'h04);
    basic = 8'h13;
    cyc(3);
    chk("status", 16'(basic), 16'(status));
    t_cmd(stb_pkg::TAG_CTRL, 10'h001, 6'h00);
    claim = 1'b1;
    busy = 1'b1;
    cyc(2);
    chk("priority_select", 16'h1, 16'(psel));
    chk("busy_seen", 16'h1, 16'(busy_seen));
    end_sim;
  end
  initial begin
    #80000;
    fail_count++;
    end_sim;
  end
endmodule
